// ===== rtl/hcmi_pkg.sv
// Constants and types of the host command and mailbox block.
// Assumes a single adapter clock and a byte-wide host memory port.
package hcmi_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the Wishbone slave)
	// ****************************************************************
	localparam logic [7:0] OFS_CMD      = 8'h00;
	localparam logic [7:0] OFS_DIN      = 8'h04;
	localparam logic [7:0] OFS_STAT     = 8'h08;
	localparam logic [7:0] OFS_DISC     = 8'h0c;
	localparam logic [7:0] OFS_BRETRY   = 8'h10;
	localparam logic [7:0] OFS_MBX_BASE = 8'h14;
	localparam logic [7:0] OFS_MBX_CNT  = 8'h18;
	localparam logic [7:0] OFS_OUT_CTL  = 8'h1c;
	localparam logic [7:0] OFS_OUT_ENT  = 8'h20;
	localparam logic [7:0] OFS_IN_CTL   = 8'h24;
	localparam logic [7:0] OFS_IN_ADDR  = 8'h28;
	localparam logic [7:0] OFS_TGT_LEN  = 8'h2c;
	localparam logic [7:0] OFS_TGT_DATA = 8'h30;

	// ****************************************************************
	// Status bit positions
	// ****************************************************************
	localparam int ST_IDLE   = 0;
	localparam int ST_DINRDY = 1;
	localparam int ST_CMDC   = 2;
	localparam int ST_CMDINV = 3;
	localparam int ST_OUTVLD = 4;
	localparam int ST_INDONE = 5;
	localparam int ST_INFAIL = 6;

	// ****************************************************************
	// Opcodes, reply values, mailbox codes
	// ****************************************************************
	localparam logic [7:0] OP_INQ_SETUP  = 8'h0d;
	localparam logic [7:0] OP_SET_OPTS   = 8'h21;
	localparam logic [7:0] OP_INQ_EXT    = 8'h8d;
	localparam logic [7:0] OP_WR_INQBUF  = 8'h9a;
	localparam logic [7:0] OP_RD_INQBUF  = 8'h9b;
	localparam logic [7:0] OPT_REMAIN    = 8'h02;
	localparam logic [7:0] OPT_RESET     = 8'hff;
	localparam logic [7:0] BASIC_DISC_IX = 8'h10;
	localparam logic [7:0] BUS_LETTER    = 8'h4d;
	localparam logic [7:0] ROM_OFF       = 8'h00;
	localparam logic [7:0] ROM_LOW       = 8'hc8;
	localparam logic [7:0] ROM_HIGH      = 8'hdc;
	localparam logic [7:0] SG_MAX_LO     = 8'h00;
	localparam logic [7:0] SG_MAX_HI     = 8'h20;
	localparam logic [6:0] INQ_BYTES     = 7'h40;
	localparam logic [6:0] INQ_LAST      = 7'h3f;
	localparam logic [6:0] MBX_LAST      = 7'h04;
	localparam logic [7:0] ACT_FREE      = 8'h00;
	localparam logic [7:0] CMP_FREE      = 8'h00;
	localparam logic [7:0] CMP_OK        = 8'h01;
	localparam logic [7:0] CMP_ABORTED   = 8'h02;
	localparam logic [7:0] CMP_NOTFOUND  = 8'h03;
	localparam logic [7:0] CMP_ERROR     = 8'h04;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_PARAM = 7'h02,
		S_EXEC  = 7'h04,
		S_REPLY = 7'h08,
		S_COPY  = 7'h10,
		S_OUT   = 7'h20,
		S_IN    = 7'h40
	} hcmi_state_t;

endpackage : hcmi_pkg

// ===== rtl/hcmi_mem_if.sv
// Byte request channel between the command engine and the memory port.
// Assumes one request outstanding at a time.
`timescale 1ns/1ns
interface hcmi_mem_if;
	logic        req;
	logic        we;
	logic [31:0] addr;
	logic [7:0]  wdata;
	logic        done;
	logic [7:0]  rdata;
	modport engine (output req, we, addr, wdata, input done, rdata);
	modport port   (input req, we, addr, wdata, output done, rdata);
endinterface : hcmi_mem_if

// ===== rtl/hcmi_mem_port.sv
// Bus master port: holds one byte request on the memory pins until acked.
// Assumes the memory answers on the same clock as this block.
`timescale 1ns/1ns
module hcmi_mem_port (
	input  wire logic        clk,
	input  wire logic        rst,
	hcmi_mem_if.port         mi,
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_ack
);
	logic        req_r;
	logic        we_r;
	logic [31:0] addr_r;
	logic [7:0]  wdata_r;
	logic        done_r;
	logic [7:0]  rdata_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			req_r   <= 1'b0;
			we_r    <= 1'b0;
			addr_r  <= 32'h0;
			wdata_r <= 8'h0;
			done_r  <= 1'b0;
			rdata_r <= 8'h0;
		end else begin
			done_r <= req_r & mem_ack;
			if (req_r & mem_ack) begin
				req_r   <= 1'b0;
				rdata_r <= mem_rdata;
			end else if (mi.req & ~req_r) begin
				req_r   <= 1'b1;
				we_r    <= mi.we;
				addr_r  <= mi.addr;
				wdata_r <= mi.wdata;
			end
		end
	end

	assign mem_req   = req_r;
	assign mem_we    = we_r;
	assign mem_addr  = addr_r;
	assign mem_wdata = wdata_r;
	assign mi.done   = done_r;
	assign mi.rdata  = rdata_r;
endmodule : hcmi_mem_port

// ===== rtl/hcmi_top.sv
// Host command interpreter, inquiry buffer copier and mailbox mover.
// Assumes Wishbone classic software access and a same-clock memory port.
//
// What this block does
// RQ1: options command takes three parameter bytes
// RQ2: first options byte counts remaining bytes
// RQ3: disconnect mask bit set forbids disconnect
// RQ4: busy mask bit set forbids busy retry
// RQ5: both masks read all ones after reset
// RQ6: basic inquiry reply byte 16 is mask
// RQ7: extended inquiry returns requested byte count
// RQ8: extended reply byte zero is bus letter
// RQ9: extended reply byte one is ROM code
// RQ10: reply bytes two, three give 8192
// RQ11: write inquiry copies 64 bytes from host
// RQ12: target inquiry reply limited by length
// RQ13: read inquiry copies 64 bytes to host
// RQ14: incoming entries follow the outgoing entries
// RQ15: outgoing entry is action plus address
// RQ16: host fills outgoing entry only when free
// RQ17: device frees outgoing entry after copying
// RQ18: completion codes one to three reported
// RQ19: code four reports completion with error
// RQ20: incoming written only if free, code last
`timescale 1ns/1ns
module hcmi_top
	import hcmi_pkg::*;
#(
	parameter logic [7:0] ROM_BASE_CODE = 8'hc8
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             MEM_REQ,
	output logic             MEM_WE,
	output logic      [31:0] MEM_ADDR,
	output logic      [7:0]  MEM_WDATA,
	input  wire logic [7:0]  MEM_RDATA,
	input  wire logic        MEM_ACK,
	output logic      [7:0]  DISC_DISABLE,
	output logic      [7:0]  BUSY_RETRY_DISABLE
);
	import hcmi_pkg::*;

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	function automatic logic [2:0] param_count(input logic [7:0] op);
		case (op)
			OP_SET_OPTS:  param_count = 3'd3;
			OP_INQ_SETUP: param_count = 3'd1;
			OP_INQ_EXT:   param_count = 3'd1;
			OP_WR_INQBUF: param_count = 3'd4;
			OP_RD_INQBUF: param_count = 3'd4;
			default:      param_count = 3'd0;
		endcase
	endfunction : param_count

	function automatic logic [7:0] reply_byte(input logic [7:0] op,
		input logic [7:0] ix, input logic [7:0] disc, input logic [7:0] rom);
		reply_byte = 8'h00;
		if (op == OP_INQ_SETUP) begin
			reply_byte = (ix == BASIC_DISC_IX) ? disc : 8'h00; // RQ6
		end else begin
			case (ix)
				8'd0:    reply_byte = BUS_LETTER; // RQ8
				8'd1:    reply_byte = rom; // RQ9
				8'd2:    reply_byte = SG_MAX_LO; // RQ10
				8'd3:    reply_byte = SG_MAX_HI; // RQ10
				default: reply_byte = 8'h00;
			endcase
		end
	endfunction : reply_byte

	// ****************************************************************
	// State
	// ****************************************************************
	hcmi_state_t st_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic [7:0]  opc_r;
	logic [2:0]  pidx_r;
	logic [31:0] pbuf_r;
	logic [7:0]  rlen_r;
	logic [7:0]  ridx_r;
	logic [7:0]  din_r;
	logic        dinrdy_r;
	logic        cmdc_r;
	logic        cmdinv_r;
	logic [7:0]  disc_r;
	logic [7:0]  bretry_r;
	logic [7:0]  inq_r [64];
	logic [6:0]  cnt_r;
	logic        pend_r;
	logic [31:0] mbx_base_r;
	logic [7:0]  mbx_n_r;
	logic [7:0]  out_idx_r;
	logic [7:0]  oact_r;
	logic [23:0] oaddr_r;
	logic        outvld_r;
	logic [7:0]  in_idx_r;
	logic [7:0]  in_code_r;
	logic [23:0] in_addr_r;
	logic        indone_r;
	logic        infail_r;
	logic [7:0]  tlen_r;
	logic [6:0]  tptr_r;

	hcmi_mem_if mi ();

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire bus_req  = WB_CYC_I & WB_STB_I;
	wire fire     = bus_req & ack_r;
	wire wr       = fire & WB_WE_I & WB_SEL_I[0];
	wire rd       = fire & ~WB_WE_I;
	wire wr_cmd   = wr & (WB_ADR_I == OFS_CMD);
	wire wr_stat  = wr & (WB_ADR_I == OFS_STAT);
	wire wr_outc  = wr & (WB_ADR_I == OFS_OUT_CTL);
	wire wr_inc   = wr & (WB_ADR_I == OFS_IN_CTL);
	wire wr_tlen  = wr & (WB_ADR_I == OFS_TGT_LEN);
	wire wr_inad  = wr & (WB_ADR_I == OFS_IN_ADDR);
	wire rd_din   = rd & (WB_ADR_I == OFS_DIN);
	wire rd_tgt   = rd & (WB_ADR_I == OFS_TGT_DATA);
	wire idle     = (st_r == S_IDLE);
	wire [2:0] np = param_count(WB_DAT_I[7:0]);
	wire [2:0] opn = param_count(opc_r);
	wire [7:0] clr = wr_stat ? WB_DAT_I[7:0] : 8'h00;

	// Out-of-range ROM settings are reported as disabled
	wire rom_ok = (ROM_BASE_CODE >= ROM_LOW) && (ROM_BASE_CODE <= ROM_HIGH)
		&& (ROM_BASE_CODE[1:0] == 2'b00);
	wire [7:0] rom_code = rom_ok ? ROM_BASE_CODE : ROM_OFF; // RQ9

	// Target inquiry: valid while under both the CDB length and the buffer
	wire tgt_vld = ({1'b0, tptr_r} < tlen_r) && (tptr_r < INQ_BYTES); // RQ12
	wire [7:0] tgt_byte = inq_r[tptr_r[5:0]];

	wire [7:0] stat = {1'b0, infail_r, indone_r, outvld_r, cmdinv_r, cmdc_r,
		dinrdy_r, idle};

	logic [31:0] rd_mux;
	always_comb begin
		case (WB_ADR_I)
			OFS_DIN:      rd_mux = {24'h0, din_r};
			OFS_STAT:     rd_mux = {24'h0, stat};
			OFS_DISC:     rd_mux = {24'h0, disc_r};
			OFS_BRETRY:   rd_mux = {24'h0, bretry_r};
			OFS_MBX_BASE: rd_mux = mbx_base_r;
			OFS_MBX_CNT:  rd_mux = {24'h0, mbx_n_r};
			OFS_OUT_ENT:  rd_mux = {oact_r, oaddr_r}; // RQ15
			OFS_IN_CTL:   rd_mux = {16'h0, in_code_r, in_idx_r};
			OFS_IN_ADDR:  rd_mux = {8'h0, in_addr_r};
			OFS_TGT_LEN:  rd_mux = {24'h0, tlen_r};
			OFS_TGT_DATA: rd_mux = {23'h0, tgt_vld, tgt_byte};
			default:      rd_mux = 32'h0;
		endcase
	end

	// ****************************************************************
	// Memory requests
	// ****************************************************************
	// Incoming entries sit after all outgoing entries of the array
	wire [31:0] out_ent = mbx_base_r + {22'h0, out_idx_r, 2'b00}; // RQ14
	wire [31:0] in_ent  = mbx_base_r + {22'h0, mbx_n_r, 2'b00}
		+ {22'h0, in_idx_r, 2'b00}; // RQ14
	// The action or code byte is read first and accessed again fifth, after the address bytes
	wire [31:0] mb_off  = {30'h0, cnt_r[2] ? 2'b00 : cnt_r[1:0]};
	wire        mem_st  = (st_r == S_COPY) | (st_r == S_OUT) | (st_r == S_IN);
	wire        issue   = mem_st & ~pend_r;
	wire        done    = mi.done;
	wire [7:0]  rdb     = mi.rdata;
	wire        last_mb = (cnt_r == MBX_LAST);
	wire [1:0]  ab      = 2'd3 - cnt_r[1:0];

	assign mi.req = issue;
	assign mi.we = ((st_r == S_COPY) & (opc_r == OP_RD_INQBUF))
		| ((st_r == S_OUT) & last_mb) | ((st_r == S_IN) & (cnt_r != 7'h0));
	assign mi.addr = (st_r == S_COPY) ? pbuf_r + {25'h0, cnt_r}
		: (st_r == S_OUT) ? out_ent + mb_off : in_ent + mb_off;
	assign mi.wdata = (st_r == S_COPY) ? inq_r[cnt_r[5:0]]
		: (st_r == S_OUT) ? ACT_FREE // RQ17
		: last_mb ? in_code_r : in_addr_r[ab*8 +: 8]; // RQ20

	hcmi_mem_port u_port (
		.clk       (CLK),
		.rst       (RST),
		.mi        (mi.port),
		.mem_req   (MEM_REQ),
		.mem_we    (MEM_WE),
		.mem_addr  (MEM_ADDR),
		.mem_wdata (MEM_WDATA),
		.mem_rdata (MEM_RDATA),
		.mem_ack   (MEM_ACK)
	);

	// ****************************************************************
	// Bus slave and software registers
	// ****************************************************************
	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_r      <= 1'b0;
			dat_r      <= 32'h0;
			mbx_base_r <= 32'h0;
			mbx_n_r    <= 8'h0;
			tlen_r     <= 8'h0;
			tptr_r     <= 7'h0;
		end else begin
			ack_r <= bus_req & ~ack_r;
			dat_r <= (bus_req & ~ack_r) ? rd_mux : dat_r;
			if (wr & (WB_ADR_I == OFS_MBX_CNT))
				mbx_n_r <= WB_DAT_I[7:0];
			if (fire & WB_WE_I & (WB_ADR_I == OFS_MBX_BASE)) begin
				for (int i = 0; i < 4; i++) begin
					if (WB_SEL_I[i])
						mbx_base_r[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
				end
			end
			if (wr_tlen) begin
				tlen_r <= WB_DAT_I[7:0]; // RQ12
				tptr_r <= 7'h0;
			end else if (rd_tgt & tgt_vld) begin
				tptr_r <= tptr_r + 7'h1; // RQ12
			end
		end
	end

	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
	assign DISC_DISABLE = disc_r; // RQ3
	assign BUSY_RETRY_DISABLE = bretry_r; // RQ4

	// ****************************************************************
	// Command engine
	// ****************************************************************
	// Flags set by the engine win over a software clear in the same cycle
	wire set_c  = (st_r == S_EXEC) & (opc_r == OP_SET_OPTS)
		| (rd_din & dinrdy_r & (ridx_r + 8'h1 == rlen_r))
		| (st_r == S_EXEC) & (opn == 3'd1) & (pbuf_r[7:0] == 8'h0)
		| (st_r == S_COPY) & done & (cnt_r == INQ_LAST);
	wire set_inv = (idle & wr_cmd & (np == 3'd0))
		| (st_r == S_EXEC) & (opc_r == OP_SET_OPTS)
		& (pbuf_r[7:0] != OPT_REMAIN);

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r      <= S_IDLE;
			opc_r     <= 8'h0;
			pidx_r    <= 3'h0;
			pbuf_r    <= 32'h0;
			rlen_r    <= 8'h0;
			ridx_r    <= 8'h0;
			din_r     <= 8'h0;
			dinrdy_r  <= 1'b0;
			cmdc_r    <= 1'b0;
			cmdinv_r  <= 1'b0;
			disc_r    <= OPT_RESET; // RQ5
			bretry_r  <= OPT_RESET; // RQ5
			cnt_r     <= 7'h0;
			pend_r    <= 1'b0;
			out_idx_r <= 8'h0;
			oact_r    <= 8'h0;
			oaddr_r   <= 24'h0;
			outvld_r  <= 1'b0;
			in_idx_r  <= 8'h0;
			in_code_r <= CMP_FREE;
			in_addr_r <= 24'h0;
			indone_r  <= 1'b0;
			infail_r  <= 1'b0;
		end else begin
			cmdc_r   <= set_c | (cmdc_r & ~clr[ST_CMDC]);
			cmdinv_r <= set_inv | (cmdinv_r & ~clr[ST_CMDINV]);
			outvld_r <= ((st_r == S_OUT) & done & last_mb)
				| (outvld_r & ~clr[ST_OUTVLD]);
			indone_r <= ((st_r == S_IN) & done & last_mb)
				| (indone_r & ~clr[ST_INDONE]);
			infail_r <= ((st_r == S_IN) & done & (cnt_r == 7'h0)
				& (rdb != CMP_FREE)) | (infail_r & ~clr[ST_INFAIL]);
			if (issue)
				pend_r <= 1'b1;
			else if (done)
				pend_r <= 1'b0;
			// Loaded only while idle so a post in flight keeps its address
			if (wr_inad & idle)
				in_addr_r <= WB_DAT_I[23:0]; // RQ20
			case (st_r)
				S_IDLE: begin
					cnt_r <= 7'h0;
					if (wr_cmd & (np != 3'd0)) begin
						opc_r  <= WB_DAT_I[7:0];
						pidx_r <= 3'h0;
						st_r   <= S_PARAM;
					end else if (wr_outc) begin
						out_idx_r <= WB_DAT_I[7:0];
						st_r      <= S_OUT;
					end else if (wr_inc) begin
						in_idx_r  <= WB_DAT_I[7:0];
						in_code_r <= WB_DAT_I[15:8]; // RQ18 RQ19
						st_r      <= S_IN;
					end
				end
				S_PARAM: begin
					if (wr_cmd) begin
						pbuf_r[pidx_r[1:0]*8 +: 8] <= WB_DAT_I[7:0]; // RQ11 RQ13
						pidx_r <= pidx_r + 3'h1;
						if (pidx_r + 3'h1 == opn)
							st_r <= S_EXEC; // RQ1
					end
				end
				S_EXEC: begin
					st_r <= S_IDLE;
					if (opc_r == OP_SET_OPTS) begin
						if (pbuf_r[7:0] == OPT_REMAIN) begin // RQ2
							disc_r   <= pbuf_r[15:8]; // RQ1 RQ3
							bretry_r <= pbuf_r[23:16]; // RQ1 RQ4
						end
					end else if (opn == 3'd1) begin
						rlen_r <= pbuf_r[7:0]; // RQ7
						ridx_r <= 8'h0;
						if (pbuf_r[7:0] != 8'h0) begin
							din_r    <= reply_byte(opc_r, 8'h0, disc_r, rom_code);
							dinrdy_r <= 1'b1;
							st_r     <= S_REPLY;
						end
					end else begin
						st_r <= S_COPY; // RQ11 RQ13
					end
				end
				S_REPLY: begin
					if (rd_din & dinrdy_r) begin
						ridx_r <= ridx_r + 8'h1;
						if (ridx_r + 8'h1 == rlen_r) begin // RQ7
							dinrdy_r <= 1'b0;
							st_r     <= S_IDLE;
						end else begin
							din_r <= reply_byte(opc_r, ridx_r + 8'h1, disc_r,
								rom_code);
						end
					end
				end
				S_COPY: begin
					if (done) begin
						if (opc_r == OP_WR_INQBUF)
							inq_r[cnt_r[5:0]] <= rdb; // RQ11
						cnt_r <= cnt_r + 7'h1;
						if (cnt_r == INQ_LAST)
							st_r <= S_IDLE;
					end
				end
				S_OUT: begin
					if (done) begin
						cnt_r <= cnt_r + 7'h1;
						if (cnt_r == 7'h0)
							oact_r <= rdb; // RQ15
						else if (~last_mb)
							oaddr_r <= {oaddr_r[15:0], rdb}; // RQ15
						else
							st_r <= S_IDLE; // RQ17
					end
				end
				S_IN: begin
					if (done) begin
						cnt_r <= cnt_r + 7'h1;
						if ((cnt_r == 7'h0) & (rdb != CMP_FREE))
							st_r <= S_IDLE; // RQ20
						else if (last_mb)
							st_r <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_opt_reset: assert property (@(posedge CLK) $past(RST) |->
		disc_r == OPT_RESET && bretry_r == OPT_RESET) // RQ5
		else $error("option masks not set after reset");
	a_opt_apply: assert property (@(posedge CLK) disable iff (RST)
		st_r == S_EXEC && opc_r == OP_SET_OPTS && pbuf_r[7:0] == OPT_REMAIN
		|=> disc_r == $past(pbuf_r[15:8]) && bretry_r == $past(pbuf_r[23:16])
		&& cmdc_r) // RQ1
		else $error("options not applied");
	a_opt_len: assert property (@(posedge CLK) disable iff (RST)
		st_r == S_EXEC && opc_r == OP_SET_OPTS && pbuf_r[7:0] != OPT_REMAIN
		|=> $stable(disc_r) && cmdinv_r) // RQ2
		else $error("bad options length accepted");
	a_basic_mask: assert property (@(posedge CLK) disable iff (RST)
		st_r == S_REPLY && opc_r == OP_INQ_SETUP && ridx_r == BASIC_DISC_IX
		|-> din_r == disc_r) // RQ6
		else $error("setup byte 16 is not the mask");
	a_ext_reply: assert property (@(posedge CLK) disable iff (RST)
		st_r == S_REPLY && opc_r == OP_INQ_EXT && dinrdy_r
		|-> (ridx_r != 8'd0 || din_r == BUS_LETTER)
		&& (ridx_r != 8'd3 || din_r == SG_MAX_HI)) // RQ8
		else $error("extended reply byte wrong");
	a_reply_len: assert property (@(posedge CLK) disable iff (RST)
		st_r == S_REPLY && rd_din && ridx_r + 8'h1 == rlen_r
		|=> st_r == S_IDLE && !dinrdy_r && cmdc_r) // RQ7
		else $error("reply length not honoured");
	a_copy_end: assert property (@(posedge CLK) disable iff (RST)
		st_r == S_COPY && done && cnt_r == INQ_LAST
		|=> st_r == S_IDLE ##1 st_r == S_IDLE) // RQ11
		else $error("inquiry copy length wrong");
	a_out_free: assert property (@(posedge CLK) disable iff (RST)
		issue && st_r == S_OUT && last_mb
		|-> mi.we && mi.wdata == ACT_FREE && mi.addr == out_ent) // RQ17
		else $error("outgoing entry not released");
	a_in_order: assert property (@(posedge CLK) disable iff (RST)
		issue && st_r == S_IN
		|-> (cnt_r == 7'h0) == !mi.we
		&& (!last_mb || (mi.wdata == in_code_r && mi.addr == in_ent))) // RQ20
		else $error("incoming entry written out of order");
	a_tgt_limit: assert property (@(posedge CLK) disable iff (RST)
		rd_tgt && !tgt_vld |=> $stable(tptr_r)) // RQ12
		else $error("target reply ran past limit");

endmodule : hcmi_top

// ===== tb/hcmi_mem_model.sv
// Host memory model answering the block's byte-wide bus master port.
// Assumes one request at a time and addresses below 1024.
`timescale 1ns/1ns
module hcmi_mem_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic [1:0]  wait_n,
	output logic      [7:0]  mem_rdata,
	output logic             mem_ack
);
	// ************************************************************
	// Byte array with a settable answer delay
	// ************************************************************
	// Flat array holds outgoing entries and the incoming ones after them
	logic [7:0] mem [0:1023];
	logic [1:0] cnt_r;

	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
		mem_rdata = 8'h00;
		mem_ack = 1'b0;
		cnt_r = 2'h0;
	end

	// Idle read data toggles so a late sample never sees a stale byte
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (rst) begin
			cnt_r <= 2'h0;
		end else if (mem_req && !mem_ack) begin
			if (cnt_r >= wait_n) begin
				mem_ack <= 1'b1;
				cnt_r <= 2'h0;
				if (mem_we) begin
					mem[mem_addr[9:0]] <= mem_wdata;
				end else begin
					mem_rdata <= mem[mem_addr[9:0]];
				end
			end else begin
				cnt_r <= cnt_r + 2'h1;
			end
		end
	end
endmodule : hcmi_mem_model

// ===== tb/hcmi_top_test.sv
// Self-checking bench of the command and mailbox block.
// Assumes the memory model stands on the bus master port.
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module hcmi_top_test;
	import hcmi_pkg::*;
	// ************************************************************
	// Stimulus, bus tasks and checks
	// ************************************************************
	logic        CLK, RST, cyc, stb, we, ack, mreq, mwe, mack;
	logic [7:0]  adr, mwd, mrd, disc, brd, d, b, act, code;
	logic [3:0]  sel;
	logic [31:0] dati, dato, maddr, q, s, seed, src;
	logic [1:0]  wait_n;
	logic [23:0] cb;
	logic [7:0]  ebuf [0:63];
	int          mismatches, num_checks, cycles;

	hcmi_top hcmi_top_inst (.CLK(CLK), .RST(RST), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .MEM_REQ(mreq),
		.MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RDATA(mrd),
		.MEM_ACK(mack), .DISC_DISABLE(disc), .BUSY_RETRY_DISABLE(brd));
	hcmi_mem_model hcmi_mem_model_inst (.clk(CLK), .rst(RST), .mem_req(mreq),
		.mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd), .wait_n(wait_n),
		.mem_rdata(mrd), .mem_ack(mack));

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [7:0] exp_rep(logic [7:0] op, int i,
		logic [7:0] m);
		if (op == OP_INQ_SETUP) return (i == 16) ? m : 8'h00;
		case (i)
			0: return BUS_LETTER;
			1: return ROM_LOW;
			2: return SG_MAX_LO;
			3: return SG_MAX_HI;
			default: return 8'h00;
		endcase
	endfunction : exp_rep

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	// Request is held until ack is sampled, then released for a cycle
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] dw, output logic [31:0] dr);
		@(posedge CLK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dati <= dw;
		do @(posedge CLK); while (ack !== 1'b1);
		dr = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] dw);
		logic [31:0] t;
		wb(a, 1'b1, dw, t);
	endtask : wr

	task automatic wait_st(input int n, output logic [31:0] st);
		do wb(OFS_STAT, 1'b0, 32'h0, st); while (st[n] !== 1'b1);
	endtask : wait_st

	// Clears sticky status and picks a new memory answer delay
	task automatic clr();
		wr(OFS_STAT, 32'h7c);
		wait_n <= 2'(rnd() % 4);
	endtask : clr

	task automatic inq(input logic [7:0] op, input int n, input logic [7:0] m);
		wr(OFS_CMD, {24'h0, op});
		wr(OFS_CMD, n);
		for (int i = 0; i < n; i++) begin
			wait_st(ST_DINRDY, s);
			wb(OFS_DIN, 1'b0, 32'h0, q);
			`CHK(q[7:0], exp_rep(op, i, m))
		end
		wait_st(ST_CMDC, s);
		`CHK(s[ST_DINRDY], 1'b0)
		clr();
	endtask : inq

	task automatic opts(input logic [7:0] n, input logic [7:0] x, y);
		wr(OFS_CMD, {24'h0, OP_SET_OPTS});
		wr(OFS_CMD, {24'h0, n});
		wr(OFS_CMD, {24'h0, x});
		wr(OFS_CMD, {24'h0, y});
		wait_st((n == OPT_REMAIN) ? ST_CMDC : ST_CMDINV, s);
		clr();
	endtask : opts

	task automatic xfer(input logic [7:0] op, input logic [31:0] a);
		wr(OFS_CMD, {24'h0, op});
		for (int i = 0; i < 4; i++) wr(OFS_CMD, {24'h0, a[8*i+:8]});
		wait_st(ST_CMDC, s);
		clr();
	endtask : xfer

	always @(posedge CLK) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			test_done();
		end
	end

	initial begin
		RST = 1'b1;
		{cyc, stb, we, adr, dati, wait_n} = '0;
		sel = 4'hf;
		seed = 24543;
		{mismatches, num_checks, cycles} = '0;
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		`CHK({disc, brd}, {OPT_RESET, OPT_RESET})
		wb(OFS_BRETRY, 1'b0, 32'h0, q);
		`CHK(q[7:0], OPT_RESET)
		wb(OFS_STAT, 1'b0, 32'h0, q);
		`CHK(q, 32'h1)
		wb(8'h40, 1'b0, 32'h0, q);
		`CHK(q, 32'h0)
		inq(OP_INQ_SETUP, 17, OPT_RESET);
		for (int k = 0; k < 3; k++) begin
			d = 8'(rnd());
			b = 8'(rnd());
			opts(OPT_REMAIN, d, b);
			`CHK({disc, brd}, {d, b})
			wb(OFS_DISC, 1'b0, 32'h0, q);
			`CHK(q[7:0], d)
		end
		opts(8'h03, ~d, ~b);
		`CHK({disc, brd}, {d, b})
		// Unknown opcode is refused and the engine stays idle
		wr(OFS_CMD, 32'h5a);
		wait_st(ST_CMDINV, s);
		`CHK(s[ST_IDLE], 1'b1)
		clr();
		inq(OP_INQ_SETUP, 17, d);
		inq(OP_INQ_EXT, 0, 8'h00);
		inq(OP_INQ_EXT, 4, 8'h00);
		inq(OP_INQ_EXT, 5 + rnd() % 3, 8'h00);
		src = 32'h100 + (rnd() & 32'h7f);
		for (int i = 0; i < 64; i++) begin
			ebuf[i] = 8'(rnd());
			hcmi_mem_model_inst.mem[src + i] = ebuf[i];
		end
		xfer(OP_WR_INQBUF, src);
		wr(OFS_TGT_LEN, 32'h5);
		for (int i = 0; i < 6; i++) begin
			wb(OFS_TGT_DATA, 1'b0, 32'h0, q);
			if (i < 5) `CHK(q[8:0], {1'b1, ebuf[i]})
			else `CHK(q[8], 1'b0)
		end
		xfer(OP_RD_INQBUF, 32'h200);
		for (int i = 0; i < 64; i++)
			`CHK(hcmi_mem_model_inst.mem[32'h200 + i], ebuf[i])
		wr(OFS_MBX_BASE, 32'h300);
		wr(OFS_MBX_CNT, 32'h4);
		for (int i = 0; i < 4; i++) begin
			act = 8'(i % 2 + 1);
			cb = 24'(rnd());
			for (int j = 1; j < 4; j++)
				hcmi_mem_model_inst.mem[32'h300 + 4*i + j] = cb[8*(3-j)+:8];
			hcmi_mem_model_inst.mem[32'h300 + 4*i] = act;
			wr(OFS_OUT_CTL, i);
			wait_st(ST_OUTVLD, s);
			wb(OFS_OUT_ENT, 1'b0, 32'h0, q);
			`CHK(q, {act, cb})
			`CHK(hcmi_mem_model_inst.mem[32'h300 + 4*i], ACT_FREE)
			clr();
		end
		for (int i = 0; i < 5; i++) begin
			code = (i < 4) ? 8'(CMP_OK + i) : CMP_ABORTED;
			cb = 24'(rnd());
			if (i == 0) src = {8'h0, cb};
			wr(OFS_IN_ADDR, {8'h0, cb});
			wr(OFS_IN_CTL, {16'h0, code, 8'(i % 4)});
			wait_st((i < 4) ? ST_INDONE : ST_INFAIL, s);
			q = {hcmi_mem_model_inst.mem[32'h310 + 4*(i%4)],
				hcmi_mem_model_inst.mem[32'h311 + 4*(i%4)],
				hcmi_mem_model_inst.mem[32'h312 + 4*(i%4)],
				hcmi_mem_model_inst.mem[32'h313 + 4*(i%4)]};
			// A busy entry keeps the code and address of the first post
			s = (i < 4) ? {code, cb} : {CMP_OK, src[23:0]};
			`CHK(q, s)
			clr();
		end
		// Reset in mid-run must bring both masks back
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		`CHK({disc, brd}, {OPT_RESET, OPT_RESET})
		wb(OFS_DISC, 1'b0, 32'h0, q);
		`CHK(q[7:0], OPT_RESET)
		test_done();
	end
endmodule : hcmi_top_test
